// ---- design/host_guard_pkg.sv ----
// Package for the host write and sample bus guard.
// Assumes one 200 MHz clock shared with the host.
package host_guard_pkg;

    // ----------------------------------------
    // Widths and field positions
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int BLOCK_BIT = 5;
    localparam int CTRL_W = 8;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] RISE_EDGES = 2'h2;

    // ----------------------------------------
    // Busy state machine
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW = 3'b010,
        ST_RELEASE = 3'b100
    } busy_state_e;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic register_select;
        logic [DATA_W-1:0] wdata;
    } host_req_s;

    typedef struct packed {
        busy_state_e st;
        logic [1:0] cnt;
        logic busy_n;
        logic [CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0] rdata;
        logic data_oe;
        logic wait_req;
        logic clk_low;
        logic wr_pend;
        logic [DATA_W-1:0] wr_data;
    } guard_state_s;

endpackage : host_guard_pkg

// ---- design/host_write_and_sample_bus_guard.sv ----
// Host port guard: status/control writes, busy timing and data driver gating.
// Assumes host strobes and sample start are synchronous to core_clk.
//
// Summary of operation
// R1 - The host writes the control register with select and write strobe low and register select high.
// R2 - Select, write strobe and the converter clock phase combine into an internal write pulse.
// R3 - The write pulse is active only in the low clock phase while the strobe is asserted.
// R4 - With the block bit zero, data drivers stay off while busy is low; here data_oe can stay high in the first cycle of busy low.
// R5 - Busy goes low on the first rising edge after sample start falls.
// R6 - Busy returns high on the second rising edge after sample start rises.
// R7 - Accesses during sample start are accepted but the data bus is not driven.
// R8 - With the block bit one, busy still falls but drivers may be enabled.
// R9 - The host combines busy with select to insert wait states.
// R10 - When busy returns high, data outputs are enabled to finish a stalled access.
// R11 - Busy stays low no longer than the sample start width plus two clock periods.
// R12 - A write during sample start is stretched and completes after busy rises.
// R13 - A read with register select low returns the FIFO word, high returns the register.
// R14 - The driver of sample start holds it low for at least two clock periods.
// R15 - Strobes are ignored while select is high.
`timescale 1ns/1ps
`default_nettype none

module host_write_and_sample_bus_guard (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire host_guard_pkg::host_req_s host_req,
    input wire logic sample_start_n,
    input wire logic [host_guard_pkg::DATA_W-1:0] fifo_word,
    output logic busy_n,
    output logic [host_guard_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic host_wait_acknowledge,
    output logic output_block_while_sampling_n,
    output logic [host_guard_pkg::CTRL_W-1:0] control_reg
);

    host_guard_pkg::guard_state_s s_r;
    host_guard_pkg::guard_state_s s_nxt;
    logic sel;
    logic rd_act;
    logic wr_act;
    logic drive_ok;
    logic wr_pulse;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // R15 select gates strobes
        sel = ~host_req.cs_n;
        rd_act = sel & ~host_req.rd_n;
        wr_act = sel & ~host_req.wr_n;
        s_nxt.clk_low = ~s_r.clk_low;
        // R5 busy falls
        // R6 second rising edge
        // R11 bounded busy low
        case (s_r.st)
            host_guard_pkg::ST_IDLE: begin
                if (!sample_start_n) begin
                    s_nxt.st = host_guard_pkg::ST_LOW;
                    s_nxt.busy_n = 1'b0;
                end
            end
            host_guard_pkg::ST_LOW: begin
                if (sample_start_n) begin
                    s_nxt.st = host_guard_pkg::ST_RELEASE;
                    s_nxt.cnt = 2'h1;
                end
            end
            host_guard_pkg::ST_RELEASE: begin
                if (s_r.cnt == host_guard_pkg::RISE_EDGES - 2'h1) begin
                    s_nxt.st = host_guard_pkg::ST_IDLE;
                    s_nxt.busy_n = 1'b1;
                    s_nxt.cnt = 2'h0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 2'h1;
                end
            end
            default: begin
                s_nxt.st = host_guard_pkg::ST_IDLE;
                s_nxt.busy_n = 1'b1;
                s_nxt.cnt = 2'h0;
            end
        endcase
        // R4 block while busy low
        // R8 block bit one allows drive
        // R7 quiet bus during sampling
        drive_ok = s_r.busy_n | s_r.ctrl[host_guard_pkg::BLOCK_BIT];
        // R9 wait for the host
        s_nxt.wait_req = (rd_act | wr_act) & ~s_nxt.busy_n & ~s_r.ctrl[host_guard_pkg::BLOCK_BIT];
        // R1 register write access
        // R2 internal write pulse
        // R3 low phase overlap
        wr_pulse = wr_act & host_req.register_select & s_r.clk_low;
        // R12 stretched write
        // R10 release on busy high
        if (wr_pulse & ~drive_ok) begin
            s_nxt.wr_pend = 1'b1;
            s_nxt.wr_data = host_req.wdata;
        end else if (wr_pulse) begin
            s_nxt.ctrl = host_req.wdata[host_guard_pkg::CTRL_W-1:0];
            s_nxt.wr_pend = 1'b0;
        end else if (s_r.wr_pend & drive_ok) begin
            s_nxt.ctrl = s_r.wr_data[host_guard_pkg::CTRL_W-1:0];
            s_nxt.wr_pend = 1'b0;
        end
        // R13 read source select
        if (host_req.register_select) begin
            s_nxt.rdata = {{(host_guard_pkg::DATA_W-host_guard_pkg::CTRL_W){1'b0}}, s_r.ctrl};
        end else begin
            s_nxt.rdata = fifo_word;
        end
        s_nxt.data_oe = rd_act & drive_ok;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '{st: host_guard_pkg::ST_IDLE, cnt: 2'h0, busy_n: 1'b1,
                     ctrl: host_guard_pkg::CTRL_RST, rdata: '0, data_oe: 1'b0,
                     wait_req: 1'b0, clk_low: 1'b0, wr_pend: 1'b0, wr_data: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_n = s_r.busy_n;
    assign data_out = s_r.rdata;
    assign data_oe = s_r.data_oe;
    assign host_wait_acknowledge = s_r.wait_req;
    assign output_block_while_sampling_n = s_r.ctrl[host_guard_pkg::BLOCK_BIT];
    assign control_reg = s_r.ctrl;

endmodule // host_write_and_sample_bus_guard

`default_nettype wire

// ---- testbench/guard_monitor.sv ----
// Checker for the host port guard.
// Bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module guard_monitor (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire host_guard_pkg::host_req_s host_req,
    input wire logic sample_start_n,
    input wire logic [15:0] fifo_word,
    input wire logic busy_n,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire logic host_wait_acknowledge,
    input wire logic output_block_while_sampling_n,
    input wire logic [7:0] control_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic rd = !host_req.cs_n && !host_req.rd_n;
    sequence s_stall;
        !busy_n && !$past(busy_n) && !output_block_while_sampling_n;
    endsequence
    sequence s_rel;
        !busy_n ##1 busy_n;
    endsequence
    property p_fall; $fell(sample_start_n) |=> !busy_n; endproperty
    property p_rise; $rose(sample_start_n) |=> s_rel; endproperty
    property p_block; s_stall |-> !data_oe; endproperty
    property p_hold; s_stall |-> $stable(control_reg); endproperty
    property p_wait; s_stall ##0 rd && !sample_start_n |=> host_wait_acknowledge; endproperty
    property p_free; $rose(busy_n) && rd |-> ##[1:2] data_oe; endproperty
    property p_idle; host_req.cs_n |=> !data_oe; endproperty
    property p_src;
        !$stable(control_reg) |-> $past(!host_req.cs_n && !host_req.wr_n && host_req.register_select);
    endproperty
    property p_fifo;
        rd && busy_n && !host_req.register_select |=> data_out == $past(fifo_word);
    endproperty
    a_fall:
        assert property (p_fall) else $error("busy late");
    a_rise:
        assert property (p_rise) else $error("busy release");
    a_block:
        assert property (p_block) else $error("driver on");
    a_hold:
        assert property (p_hold) else $error("write not held");
    a_wait:
        assert property (p_wait) else $error("no wait");
    a_free:
        assert property (p_free) else $error("no release");
    a_idle:
        assert property (p_idle) else $error("unselected drive");
    a_src:
        assert property (p_src) else $error("stray write");
    a_fifo:
        assert property (p_fifo) else $error("fifo word");
endmodule // guard_monitor
`default_nettype wire

// ---- testbench/host_model.sv ----
// Host processor model with a wait input.
// Shares core_clk with the guard.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic core_clk,
    input wire logic host_wait_acknowledge,
    output var host_guard_pkg::host_req_s host_req,
    output var logic sample_start_n
);
    bit timed_out = 1'b0;
    initial begin
        host_req = '1;
        sample_start_n = 1'b1;
    end
    task automatic access(input logic rd, input logic sel, input logic [15:0] d, input int n);
        int i;
        @(posedge core_clk);
        host_req <= '{1'b0, !rd, rd, sel, d};
        repeat (n) @(posedge core_clk);
        for (i = 0; i < 20; i++) begin
            @(negedge core_clk);
            if (host_wait_acknowledge === 1'b0) break;
            @(posedge core_clk);
        end
        if (i == 20) timed_out = 1'b1;
        @(posedge core_clk);
        host_req <= '{1'b1, 1'b1, 1'b1, !sel, ~d};
    endtask
    task automatic start(input int n);
        @(posedge core_clk);
        sample_start_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        sample_start_n <= 1'b1;
    endtask
endmodule // host_model
`default_nettype wire

// ---- testbench/host_write_and_sample_bus_guard_tb.sv ----
// Bench for the host port guard.
// Drives it through the host model; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module host_write_and_sample_bus_guard_tb;
    typedef struct packed {logic rd; logic sel; logic [15:0] d; logic [7:0] c;} row_s;
    row_s rows [4] = '{'{1'b0, 1'b1, 16'h12A5, 8'hA5}, '{1'b0, 1'b0, 16'h005A, 8'hA5},
        '{1'b1, 1'b0, 16'h0000, 8'hA5}, '{1'b0, 1'b1, 16'h00DF, 8'hDF}};
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] fifo_word = 16'h0000;
    host_guard_pkg::host_req_s host_req;
    logic sample_start_n, busy_n, data_oe, host_wait_acknowledge, output_block_while_sampling_n;
    logic [15:0] data_out;
    logic [7:0] control_reg;
    int fails = 0;
    int n_compared = 0;
    host_write_and_sample_bus_guard dut (.*);
    host_model hm (.*);
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) fifo_word <= fifo_word + 16'h0001;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (hm.timed_out) fails++;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_oe;
        int i;
        for (i = 0; i < 12 && data_oe !== 1'b1; i++) #5;
        if (i == 12) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic stall(input logic rd, input logic [15:0] d, input logic oe, input logic [7:0] c);
        #40;
        fork
            hm.start(3);
            begin @(posedge core_clk); hm.access(rd, 1'b1, d, 2); end
        join_none
        repeat (2) @(posedge core_clk);
        #1;
        chk(busy_n, 1'b0);
        #10;
        chk(data_oe, oe);
        chk(control_reg, c);
        #5;
        chk(busy_n, 1'b0);
        #5;
        chk(busy_n, 1'b1);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        chk(data_oe, 1'b0);
        chk(control_reg, 16'h0000);
        @(posedge core_clk) arst_n <= 1'b1;
        foreach (rows[i]) begin
            hm.access(rows[i].rd, rows[i].sel, rows[i].d, 2);
            #11;
            chk(control_reg, rows[i].c);
        end
        stall(1'b1, 16'h0000, 1'b0, 8'hDF);
        wait_oe();
        chk(data_out, 16'h00DF);
        stall(1'b0, 16'h0020, 1'b0, 8'hDF);
        #40;
        chk(control_reg, 16'h0020);
        stall(1'b1, 16'h0000, 1'b1, 8'h20);
        #40;
        tally_and_finish();
    end
endmodule // host_write_and_sample_bus_guard_tb
bind host_write_and_sample_bus_guard guard_monitor mon (.*);
`default_nettype wire
